// ==== fifth_reduced_gmii_port_cfg_regs.svh ====
`ifndef FIFTH_REDUCED_GMII_PORT_CFG_REGS_SVH
`define FIFTH_REDUCED_GMII_PORT_CFG_REGS_SVH

// Register indices; the APB byte address is four times the index
`define RG5_IDX_CLK_DELAY 16'hf101
`define RG5_IDX_EBUF_CTL 16'hf120
`define RG5_IDX_PORT_MUX 16'hf130
`define RG5_IDX_IFACE_MODE 16'hf1f0
`define RG5_IDX_IRQ_STATUS 16'hf1f1
`define RG5_IDX_IRQ_MASK 16'hf1f2

// Clock delay register fields
`define RG5_CD_METHOD_BIT 10
`define RG5_CD_RX_MSB 9
`define RG5_CD_RX_LSB 7
`define RG5_CD_TX_MSB 2
`define RG5_CD_TX_LSB 0
`define RG5_CD_RESET 16'h0000

// Elastic buffer control fields
`define RG5_EB_TX_UFL_BIT 15
`define RG5_EB_TX_OFL_BIT 14
`define RG5_EB_RX_UFL_BIT 13
`define RG5_EB_RX_OFL_BIT 12
`define RG5_EB_FLAG_LSB 12
`define RG5_EB_TXWP_MSB 5
`define RG5_EB_TXWP_LSB 3
`define RG5_EB_RXWP_MSB 2
`define RG5_EB_RXWP_LSB 0
`define RG5_EB_RESET 16'h0009

// Port mux fields
`define RG5_MUX_IE_BIT 9
`define RG5_MUX_ISO_BIT 0
`define RG5_MUX_RESET 16'h0000

// Interface mode field
`define RG5_IFMODE_MSB 3
`define RG5_IFMODE_RGMII 4'h4
`define RG5_IFMODE_RESET 4'h0

// Interrupt registers, one bit per buffer event
`define RG5_IRQ_RESET 4'h0

// Delay step
`define RG5_DELAY_STEP_PS 12'h1f4

`endif

// ==== fifth_reduced_gmii_port_cfg_pkg.sv ====
package fifth_reduced_gmii_port_cfg_pkg;
`include "fifth_reduced_gmii_port_cfg_regs.svh"

    typedef logic [2:0] delay_step_t;
    typedef logic [11:0] delay_ps_t;
    typedef enum logic
    {
        DELAY_DIRECT = 1'b0,
        DELAY_MK = 1'b1
    } delay_method_t;
    typedef enum logic [2:0]
    {
        SEL_NONE = 3'h0,
        SEL_CLK_DELAY = 3'h1,
        SEL_EBUF_CTL = 3'h3,
        SEL_PORT_MUX = 3'h2,
        SEL_IFACE_MODE = 3'h6,
        SEL_IRQ_STATUS = 3'h7,
        SEL_IRQ_MASK = 3'h5
    } reg_sel_t;
endpackage

// ==== sticky_bits.sv ====
`timescale 1ns/1ps
module sticky_bits #(
    parameter int WIDTH = 4
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] set,
    input wire logic [WIDTH-1:0] clr,
    output logic [WIDTH-1:0] bits
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            logic q;
            // Set beats a clear in the same cycle
            always_ff @(posedge core_clk or negedge rst_n)
            begin
                if (!rst_n)
                    q <= 1'b0;
                else if (set[i])
                    q <= 1'b1;
                else if (clr[i])
                    q <= 1'b0;
            end
            // One flop per bit, so each bit has a single driver
            assign bits[i] = q;
        end
    endgenerate
endmodule // sticky_bits

// ==== fifth_reduced_gmii_port_port_cfg.sv ====
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
`include "fifth_reduced_gmii_port_cfg_regs.svh"
// How it works
// - Delay method bit 10 picks direct delay fields when 0 and M/K derived delays when 1.
// - Receive clock delay is the unsigned bits 9:7 value times 500 ps.
// - Transmit clock delay is the unsigned bits 2:0 value times 500 ps.
// - Bit 15 latches once a transmit buffer underflow is seen.
// - Bit 14 latches once a transmit buffer overflow is seen.
// - Bit 13 latches once a receive buffer underflow is seen.
// - Bit 12 latches once a receive buffer overflow is seen.
// - The transmit buffer write pointer starts offset by bits 5:3.
// - The receive buffer write pointer starts offset by bits 2:0.
// - Mux bit 9 set attaches switch port 6 to the insertion and extraction path.
// - Mux bit 0 set routes the first internal PHY to the fifth port instead of the fabric.
// - The port is RGMII, and the clock delays apply, only when the mode field holds 0100.
module fifth_reduced_gmii_port_port_cfg #(
    parameter int ADDR_W = 20
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic tx_underflow_evt,
    input wire logic tx_overflow_evt,
    input wire logic rx_underflow_evt,
    input wire logic rx_overflow_evt,
    output logic delay_method_select,
    output logic [11:0] receive_clock_delay_ps,
    output logic [11:0] transmit_clock_delay_ps,
    output logic [2:0] tx_write_pointer_delay,
    output logic [2:0] rx_write_pointer_delay,
    output logic insert_extract_mode,
    output logic first_phy_isolate,
    output logic rgmii_active,
    output logic irq
);
    fifth_reduced_gmii_port_cfg_pkg::delay_method_t delay_method;
    fifth_reduced_gmii_port_cfg_pkg::delay_step_t receive_clock_delay;
    fifth_reduced_gmii_port_cfg_pkg::delay_step_t transmit_clock_delay;
    logic [3:0] interface_mode_field;
    logic [3:0] irq_mask;
    logic [3:0] irq_status;
    logic [3:0] ebuf_flags;
    logic [3:0] buf_events;
    logic [3:0] flag_clr;
    logic [3:0] irq_clr;
    logic [15:0] next_rdata;
    logic [15:0] cd_merged;
    fifth_reduced_gmii_port_cfg_pkg::reg_sel_t sel;
    logic access;
    logic wr_en;
    logic rd_done;

    function automatic logic [ADDR_W-1:0] byte_addr(input logic [15:0] idx);
        byte_addr = ADDR_W'({idx, 2'b00});
    endfunction

    function automatic fifth_reduced_gmii_port_cfg_pkg::reg_sel_t decode(input logic [ADDR_W-1:0] a);
        if (a == byte_addr(`RG5_IDX_CLK_DELAY))
            decode = fifth_reduced_gmii_port_cfg_pkg::SEL_CLK_DELAY;
        else if (a == byte_addr(`RG5_IDX_EBUF_CTL))
            decode = fifth_reduced_gmii_port_cfg_pkg::SEL_EBUF_CTL;
        else if (a == byte_addr(`RG5_IDX_PORT_MUX))
            decode = fifth_reduced_gmii_port_cfg_pkg::SEL_PORT_MUX;
        else if (a == byte_addr(`RG5_IDX_IFACE_MODE))
            decode = fifth_reduced_gmii_port_cfg_pkg::SEL_IFACE_MODE;
        else if (a == byte_addr(`RG5_IDX_IRQ_STATUS))
            decode = fifth_reduced_gmii_port_cfg_pkg::SEL_IRQ_STATUS;
        else if (a == byte_addr(`RG5_IDX_IRQ_MASK))
            decode = fifth_reduced_gmii_port_cfg_pkg::SEL_IRQ_MASK;
        else
            decode = fifth_reduced_gmii_port_cfg_pkg::SEL_NONE;
    endfunction

    // Per-lane merge of a 16-bit register with the write data
    function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] be);
        merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction

    // Zero wait states; unmapped accesses complete with an error and no effect
    assign sel = decode(paddr);
    assign access = psel && penable;
    assign pready = 1'b1;
    assign pslverr = access && (sel == fifth_reduced_gmii_port_cfg_pkg::SEL_NONE);
    assign wr_en = access && pwrite;
    assign rd_done = access && !pwrite && (sel == fifth_reduced_gmii_port_cfg_pkg::SEL_EBUF_CTL);
    // Receive field straddles both byte lanes
    assign cd_merged = merge({5'h00, delay_method, receive_clock_delay, 4'h0, transmit_clock_delay}, pwdata, pstrb);

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            delay_method <= fifth_reduced_gmii_port_cfg_pkg::delay_method_t'(1'(`RG5_CD_RESET >> `RG5_CD_METHOD_BIT));
            receive_clock_delay <= 3'(`RG5_CD_RESET >> `RG5_CD_RX_LSB);
            transmit_clock_delay <= 3'(`RG5_CD_RESET >> `RG5_CD_TX_LSB);
        end
        else if (wr_en && sel == fifth_reduced_gmii_port_cfg_pkg::SEL_CLK_DELAY)
        begin
            delay_method <= fifth_reduced_gmii_port_cfg_pkg::delay_method_t'(cd_merged[`RG5_CD_METHOD_BIT]);
            receive_clock_delay <= cd_merged[`RG5_CD_RX_MSB:`RG5_CD_RX_LSB];
            transmit_clock_delay <= cd_merged[`RG5_CD_TX_MSB:`RG5_CD_TX_LSB];
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_write_pointer_delay <= 3'(`RG5_EB_RESET >> `RG5_EB_TXWP_LSB);
            rx_write_pointer_delay <= 3'(`RG5_EB_RESET >> `RG5_EB_RXWP_LSB);
        end
        else if (wr_en && sel == fifth_reduced_gmii_port_cfg_pkg::SEL_EBUF_CTL && pstrb[0])
        begin
            // Range is software's duty; the block takes any value
            tx_write_pointer_delay <= pwdata[`RG5_EB_TXWP_MSB:`RG5_EB_TXWP_LSB];
            rx_write_pointer_delay <= pwdata[`RG5_EB_RXWP_MSB:`RG5_EB_RXWP_LSB];
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            insert_extract_mode <= 1'(`RG5_MUX_RESET >> `RG5_MUX_IE_BIT);
            first_phy_isolate <= 1'(`RG5_MUX_RESET >> `RG5_MUX_ISO_BIT);
        end
        else if (wr_en && sel == fifth_reduced_gmii_port_cfg_pkg::SEL_PORT_MUX)
        begin
            if (pstrb[1])
                insert_extract_mode <= pwdata[`RG5_MUX_IE_BIT];
            if (pstrb[0])
                first_phy_isolate <= pwdata[`RG5_MUX_ISO_BIT];
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            interface_mode_field <= `RG5_IFMODE_RESET;
        else if (wr_en && sel == fifth_reduced_gmii_port_cfg_pkg::SEL_IFACE_MODE && pstrb[0])
            interface_mode_field <= pwdata[`RG5_IFMODE_MSB:0];
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            irq_mask <= `RG5_IRQ_RESET;
        else if (wr_en && sel == fifth_reduced_gmii_port_cfg_pkg::SEL_IRQ_MASK && pstrb[0])
            irq_mask <= pwdata[3:0];
    end

    // Flag order matches bits 15:12 of the buffer control register
    assign buf_events = {tx_underflow_evt, tx_overflow_evt, rx_underflow_evt, rx_overflow_evt};

    // Only bits that the read returned as one are cleared, so a later event is kept
    assign flag_clr = rd_done ? prdata[`RG5_EB_TX_UFL_BIT:`RG5_EB_FLAG_LSB] : 4'h0;

    sticky_bits #(
        .WIDTH(4)
    ) u_ebuf_flags (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .set(buf_events),
        .clr(flag_clr),
        .bits(ebuf_flags)
    );

    assign irq_clr = (wr_en && sel == fifth_reduced_gmii_port_cfg_pkg::SEL_IRQ_STATUS && pstrb[0]) ? pwdata[3:0] : 4'h0;

    sticky_bits #(
        .WIDTH(4)
    ) u_irq_status (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .set(buf_events),
        .clr(irq_clr),
        .bits(irq_status)
    );

    assign irq = |(irq_status & irq_mask);

    // Read data is captured in the setup cycle and held through the access
    always_comb
    begin
        next_rdata = 16'h0000;
        unique case (sel)
            fifth_reduced_gmii_port_cfg_pkg::SEL_CLK_DELAY:
                next_rdata = {5'h00, delay_method, receive_clock_delay, 4'h0, transmit_clock_delay};
            fifth_reduced_gmii_port_cfg_pkg::SEL_EBUF_CTL:
                next_rdata = {ebuf_flags, 6'h00, tx_write_pointer_delay, rx_write_pointer_delay};
            fifth_reduced_gmii_port_cfg_pkg::SEL_PORT_MUX:
                next_rdata = {6'h00, insert_extract_mode, 8'h00, first_phy_isolate};
            fifth_reduced_gmii_port_cfg_pkg::SEL_IFACE_MODE:
                next_rdata = {12'h000, interface_mode_field};
            fifth_reduced_gmii_port_cfg_pkg::SEL_IRQ_STATUS:
                next_rdata = {12'h000, irq_status};
            fifth_reduced_gmii_port_cfg_pkg::SEL_IRQ_MASK:
                next_rdata = {12'h000, irq_mask};
            fifth_reduced_gmii_port_cfg_pkg::SEL_NONE:
                next_rdata = 16'h0000;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            prdata <= 32'h0000_0000;
        else if (psel && !penable && !pwrite)
            prdata <= {16'h0000, next_rdata};
    end

    // Delay outputs; zero whenever the direct fields do not govern the delay
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rgmii_active <= 1'b0;
            delay_method_select <= 1'b0;
            receive_clock_delay_ps <= 12'h000;
            transmit_clock_delay_ps <= 12'h000;
        end
        else
        begin
            rgmii_active <= interface_mode_field == `RG5_IFMODE_RGMII;
            delay_method_select <= (interface_mode_field == `RG5_IFMODE_RGMII) &&
                (delay_method == fifth_reduced_gmii_port_cfg_pkg::DELAY_MK);
            if (interface_mode_field == `RG5_IFMODE_RGMII && delay_method == fifth_reduced_gmii_port_cfg_pkg::DELAY_DIRECT)
            begin
                receive_clock_delay_ps <= 12'(receive_clock_delay) * `RG5_DELAY_STEP_PS;
                transmit_clock_delay_ps <= 12'(transmit_clock_delay) * `RG5_DELAY_STEP_PS;
            end
            else
            begin
                receive_clock_delay_ps <= 12'h000;
                transmit_clock_delay_ps <= 12'h000;
            end
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    a_method_mk_gate: assert property (
        (interface_mode_field == `RG5_IFMODE_RGMII && delay_method == fifth_reduced_gmii_port_cfg_pkg::DELAY_MK)
        |=> (delay_method_select && receive_clock_delay_ps == 12'h000 && transmit_clock_delay_ps == 12'h000))
        else $error("MK method did not zero the direct delays");

    a_rx_delay_value: assert property (
        (interface_mode_field == `RG5_IFMODE_RGMII && delay_method == fifth_reduced_gmii_port_cfg_pkg::DELAY_DIRECT)
        |=> receive_clock_delay_ps == 12'($past(receive_clock_delay)) * 12'd500)
        else $error("Receive delay is not step times 500 ps");

    a_tx_delay_value: assert property (
        (interface_mode_field == `RG5_IFMODE_RGMII && delay_method == fifth_reduced_gmii_port_cfg_pkg::DELAY_DIRECT)
        |=> transmit_clock_delay_ps == 12'($past(transmit_clock_delay)) * 12'd500)
        else $error("Transmit delay is not step times 500 ps");

    a_tx_ufl_latch: assert property (
        tx_underflow_evt |=> ebuf_flags[3] && irq_status[3])
        else $error("Transmit underflow not latched");

    a_tx_ofl_latch: assert property (
        tx_overflow_evt |=> ebuf_flags[2])
        else $error("Transmit overflow not latched");

    a_rx_ufl_latch: assert property (
        rx_underflow_evt |=> ebuf_flags[1])
        else $error("Receive underflow not latched");

    a_rx_ofl_hold: assert property (
        (ebuf_flags[0] && !rd_done) |=> ebuf_flags[0])
        else $error("Receive overflow flag dropped without a read");

    a_tx_wp_write: assert property (
        (wr_en && sel == fifth_reduced_gmii_port_cfg_pkg::SEL_EBUF_CTL && pstrb[0])
        |=> tx_write_pointer_delay == $past(pwdata[5:3]))
        else $error("Transmit write pointer delay not taken");

    a_rx_wp_write: assert property (
        (wr_en && sel == fifth_reduced_gmii_port_cfg_pkg::SEL_EBUF_CTL && pstrb[0])
        |=> rx_write_pointer_delay == $past(pwdata[2:0]))
        else $error("Receive write pointer delay not taken");

    a_ie_mode_write: assert property (
        (wr_en && sel == fifth_reduced_gmii_port_cfg_pkg::SEL_PORT_MUX && pstrb[1]) |=> insert_extract_mode == $past(pwdata[9]))
        else $error("Insert extract mode not taken");

    a_phy_iso_write: assert property (
        (wr_en && sel == fifth_reduced_gmii_port_cfg_pkg::SEL_PORT_MUX && pstrb[0]) |=> first_phy_isolate == $past(pwdata[0]))
        else $error("PHY isolation not taken");

    a_non_rgmii_zero: assert property (
        (interface_mode_field != `RG5_IFMODE_RGMII) |=> (!rgmii_active && !delay_method_select &&
        receive_clock_delay_ps == 12'h000 && transmit_clock_delay_ps == 12'h000))
        else $error("Delays applied outside RGMII mode");

    a_flag_read_clear: assert property (
        (rd_done && prdata[15] && !tx_underflow_evt) |=> !ebuf_flags[3] ##1 !ebuf_flags[3] || $past(tx_underflow_evt))
        else $error("Read did not clear transmit underflow flag");

    a_flag_read_keep: assert property (
        (rd_done && tx_underflow_evt) |=> ebuf_flags[3])
        else $error("Event during read was lost");

    c_flag_read: cover property (tx_underflow_evt ##[1:20] rd_done);
    c_irq_rise: cover property ($rose(irq));
    c_direct_delay: cover property (rgmii_active && receive_clock_delay_ps != 12'h000);
    c_mk_mode: cover property (delay_method_select);
endmodule // fifth_reduced_gmii_port_port_cfg

// ==== fifth_reduced_gmii_port_event_source.sv ====
`timescale 1ns/1ps
// Stands in for the elastic buffers behind the port: one-cycle event pulses on request
module fifth_reduced_gmii_port_event_source (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [3:0] fire,
    output logic tx_underflow_evt,
    output logic tx_overflow_evt,
    output logic rx_underflow_evt,
    output logic rx_overflow_evt
);
    // Registered so a pulse changes only at a clock edge, one cycle after fire
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            {tx_underflow_evt, tx_overflow_evt, rx_underflow_evt, rx_overflow_evt} <= 4'h0;
        end
        else
        begin
            {tx_underflow_evt, tx_overflow_evt, rx_underflow_evt, rx_overflow_evt} <= fire;
        end
    end
endmodule // fifth_reduced_gmii_port_event_source

// ==== fifth_reduced_gmii_port_port_cfg_bench.sv ====
`timescale 1ns/1ps
`include "fifth_reduced_gmii_port_cfg_regs.svh"
module fifth_reduced_gmii_port_port_cfg_bench;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [19:0] paddr = 20'h00000;
    logic [31:0] pwdata = 32'h00000000;
    logic [3:0] pstrb = 4'h0;
    logic [3:0] fire = 4'h0;
    logic [31:0] prdata;
    logic pready, pslverr, tx_ufl, tx_ofl, rx_ufl, rx_ofl;
    logic delay_method_select, insert_extract_mode, first_phy_isolate, rgmii_active, irq;
    logic [11:0] rx_ps, tx_ps;
    logic [2:0] tx_wp, rx_wp;
    logic [31:0] rd;
    logic err;
    int n_fail = 0;
    int checks = 0;
    localparam logic [15:0] WP = 16'h000e;

    fifth_reduced_gmii_port_port_cfg dut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tx_underflow_evt(tx_ufl), .tx_overflow_evt(tx_ofl), .rx_underflow_evt(rx_ufl),
        .rx_overflow_evt(rx_ofl), .delay_method_select(delay_method_select),
        .receive_clock_delay_ps(rx_ps), .transmit_clock_delay_ps(tx_ps), .tx_write_pointer_delay(tx_wp),
        .rx_write_pointer_delay(rx_wp), .insert_extract_mode(insert_extract_mode),
        .first_phy_isolate(first_phy_isolate), .rgmii_active(rgmii_active), .irq(irq));
    fifth_reduced_gmii_port_event_source events (.core_clk(core_clk), .rst_n(rst_n), .fire(fire), .tx_underflow_evt(tx_ufl),
        .tx_overflow_evt(tx_ofl), .rx_underflow_evt(rx_ufl), .rx_overflow_evt(rx_ofl));

    initial
    begin
        forever #2.5 core_clk = ~core_clk;
    end

    function automatic logic [19:0] ba(input logic [15:0] idx);
        return {2'b00, idx, 2'b00};
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // Entered just after an edge; leaves one idle edge so no signal is driven twice in a step
    task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= ba(idx);
        pwdata <= d;
        pstrb <= 4'h3;
        @(posedge core_clk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for pready
        do
        begin
            @(posedge core_clk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic pulse(input logic [3:0] m);
        fire <= m;
        @(posedge core_clk);
        fire <= 4'h0;
        tick(3);
    endtask

    task automatic complete_run();
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        #100000;
        n_fail++;
        complete_run();
    end

    initial
    begin
        tick(4);
        rst_n <= 1'b1;
        tick(1);
        // Reset values and access kinds
        apb(0, `RG5_IDX_CLK_DELAY, 0);
        chk(rd, 32'h00000000);
        apb(0, `RG5_IDX_EBUF_CTL, 0);
        chk(rd, 32'h00000009);
        apb(0, `RG5_IDX_PORT_MUX, 0);
        chk(rd, 32'h00000000);
        chk({31'h0, err}, 32'h0);
        chk({29'h0, tx_wp}, 32'h1);
        chk({29'h0, rx_wp}, 32'h1);
        chk({31'h0, irq}, 32'h0);
        apb(0, 16'h0010, 0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h00000000);
        $display("test reset_and_map done");
        // Every step of both delay fields, both ends of the range
        apb(1, `RG5_IDX_IFACE_MODE, 32'h4);
        for (int s = 0; s < 8; s++)
        begin
            apb(1, `RG5_IDX_CLK_DELAY, (s << 7) | (7 - s));
            tick(2);
            chk({20'h0, rx_ps}, s * 500);
            chk({20'h0, tx_ps}, (7 - s) * 500);
            chk({31'h0, rgmii_active}, 32'h1);
            apb(0, `RG5_IDX_CLK_DELAY, 0);
            chk(rd, (s << 7) | (7 - s));
        end
        apb(1, `RG5_IDX_CLK_DELAY, 32'h000005bb);
        tick(2);
        chk({31'h0, delay_method_select}, 32'h1);
        chk({20'h0, rx_ps}, 32'h0);
        apb(1, `RG5_IDX_CLK_DELAY, 32'h000001bb);
        apb(1, `RG5_IDX_IFACE_MODE, 32'h5);
        tick(2);
        chk({31'h0, rgmii_active}, 32'h0);
        chk({20'h0, tx_ps}, 32'h0);
        apb(1, `RG5_IDX_IFACE_MODE, 32'h4);
        tick(2);
        chk({20'h0, tx_ps}, 32'd1500);
        $display("test clock_delay done");
        // Delays kept inside 1..6; flag bits are read-only
        apb(1, `RG5_IDX_EBUF_CTL, 32'h0000f00e);
        tick(2);
        chk({29'h0, tx_wp}, 32'h1);
        chk({29'h0, rx_wp}, 32'h6);
        apb(0, `RG5_IDX_EBUF_CTL, 0);
        chk(rd, {16'h0, WP});
        apb(1, `RG5_IDX_PORT_MUX, 32'h00000201);
        tick(2);
        chk({31'h0, insert_extract_mode}, 32'h1);
        chk({31'h0, first_phy_isolate}, 32'h1);
        apb(1, `RG5_IDX_PORT_MUX, 32'h00000200);
        tick(2);
        chk({31'h0, first_phy_isolate}, 32'h0);
        apb(1, `RG5_IDX_PORT_MUX, 32'h00000001);
        tick(2);
        chk({31'h0, insert_extract_mode}, 32'h0);
        $display("test buffer_and_mux done");
        // Each event: flag, clear on read, interrupt raise and clear
        for (int i = 0; i < 4; i++)
        begin
            apb(1, `RG5_IDX_IRQ_MASK, 1 << i);
            pulse(4'h1 << i);
            chk({31'h0, irq}, 32'h1);
            apb(0, `RG5_IDX_IRQ_STATUS, 0);
            chk(rd, 1 << i);
            apb(0, `RG5_IDX_EBUF_CTL, 0);
            chk(rd, (1 << (12 + i)) | WP);
            apb(0, `RG5_IDX_EBUF_CTL, 0);
            chk(rd, {16'h0, WP});
            apb(1, `RG5_IDX_IRQ_STATUS, 1 << i);
            chk({31'h0, irq}, 32'h0);
        end
        apb(1, `RG5_IDX_IRQ_MASK, 32'h0);
        pulse(4'h8);
        chk({31'h0, irq}, 32'h0);
        apb(1, `RG5_IDX_IRQ_MASK, 32'h8);
        chk({31'h0, irq}, 32'h1);
        apb(1, `RG5_IDX_IRQ_STATUS, 32'h8);
        chk({31'h0, irq}, 32'h0);
        // New event lands during the clearing read
        fork
            apb(0, `RG5_IDX_EBUF_CTL, 0);
            begin
                fire <= 4'h8;
                @(posedge core_clk);
                fire <= 4'h0;
            end
        join
        chk(rd, 32'h8000 | WP);
        apb(0, `RG5_IDX_EBUF_CTL, 0);
        chk(rd, 32'h8000 | WP);
        apb(0, `RG5_IDX_EBUF_CTL, 0);
        chk(rd, {16'h0, WP});
        $display("test events done");
        complete_run();
    end
endmodule // fifth_reduced_gmii_port_port_cfg_bench
